// ===== common/flt_pkg.sv
// Behaviour
// - table registers always readable; writes need unlock
// - low-res temperature: limit bit 7 held zero
// - high-res temperature: eight-bit half-degree limit
// - low-res temperature: whole degrees 0..127
// - reading above limit selects paired duty
// - compare nine bits high-res, eight low-res
// - limits are non-negative, sign bit zero
// - table offset extends limits past 127
// - low-res duty: bits 7:6 held zero
// - high-res duty: bits 7:0 one value
// - extended duty bits only at 22.5kHz
// - low-res duty uses bits 5:0 only
package flt_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] FLT_ADDR_LIMIT_ELEVEN  = 8'h64;
	localparam logic [7:0] FLT_ADDR_DUTY_ELEVEN   = 8'h65;
	localparam logic [7:0] FLT_ADDR_LIMIT_TWELVE  = 8'h66;
	localparam logic [7:0] FLT_ADDR_DUTY_TWELVE   = 8'h67;
	localparam logic [7:0] FLT_LIMIT_RESET        = 8'h7f;
	localparam logic [7:0] FLT_DUTY_RESET         = 8'h3f;
	localparam int         FLT_HALF_DEGREE_BIT    = 7;
	localparam int         FLT_EXT_DUTY_LSB       = 6;
	localparam logic [7:0] FLT_LOW_RES_MASK_LIMIT = 8'h7f;
	localparam logic [7:0] FLT_LOW_RES_MASK_DUTY  = 8'h3f;
	localparam int         FLT_ENTRIES            = 2;
	localparam int         FLT_WORDS              = 4;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} flt_bus_req_t;

	typedef struct packed {
		logic       temp_high_res;
		logic       duty_high_res;
		logic       pwm_freq_22k5;
		logic       write_unlock;
		logic [7:0] table_offset;
	} flt_cfg_t;

	typedef struct packed {
		logic       hit_eleven;
		logic       hit_twelve;
		logic       duty_valid;
		logic [7:0] duty;
		logic       rd_valid;
		logic [7:0] rdata;
		logic       rd_pend;
		logic       rd_duty;
	} flt_state_t;

endpackage

// ===== src/flt_entry_store.sv
`timescale 1ns/1ns
// ****************************************
// storage for the two limit/duty pairs
// ****************************************
module flt_entry_store (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	// write side
	input  wire logic [3:0] wr_en_in,
	input  wire logic [7:0] wdata_in,
	// read side
	input  wire logic [1:0] rd_sel_in,
	output logic [7:0]      rdata_out,
	output logic [31:0]     all_out
);
	typedef struct packed {
		logic [flt_pkg::FLT_WORDS-1:0][7:0] word;
		logic [7:0]                         rdata;
	} flt_store_state_t;

	flt_store_state_t                        st_reg;
	flt_store_state_t                        st_next;
	wire logic [flt_pkg::FLT_WORDS-1:0][7:0] word_next;

	// each word loads only on its own enable
	genvar g;
	generate
		for (g = 0; g < flt_pkg::FLT_WORDS; g++) begin : g_word
			assign word_next[g] = wr_en_in[g] ? wdata_in : st_reg.word[g];
		end
	endgenerate

	always_comb begin
		st_next       = st_reg;
		st_next.word  = word_next;
		st_next.rdata = st_reg.word[rd_sel_in];
	end

	// limits sit at even words, duties at odd words
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_reg <= '{word: {flt_pkg::FLT_DUTY_RESET, flt_pkg::FLT_LIMIT_RESET,
				flt_pkg::FLT_DUTY_RESET, flt_pkg::FLT_LIMIT_RESET}, rdata: 8'h00};
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_out = st_reg.rdata;
	assign all_out   = st_reg.word;
endmodule // flt_entry_store

// ===== src/flt_lut_top.sv
`timescale 1ns/1ns
module flt_lut_top (
	// clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 sys_rst_in,
	// register port
	input  wire flt_pkg::flt_bus_req_t bus_in,
	output logic                      rd_valid_out,
	output logic [7:0]                rdata_out,
	// configuration from outside registers
	input  wire flt_pkg::flt_cfg_t     cfg_in,
	// remote reading: bits 10:0 unsigned, 1/8 degree lsb
	input  wire logic [10:0]          remote_temp_in,
	// fan table results
	output logic                      hit_eleven_out,
	output logic                      hit_twelve_out,
	output logic                      duty_valid_out,
	output logic [7:0]                duty_out
);
	flt_pkg::flt_state_t st_reg;
	flt_pkg::flt_state_t st_next;

	// register port decode
	logic                                 in_range;
	logic                                 wr_req;
	logic                                 rd_req;
	logic                                 wr_allow;
	logic                                 wr_is_duty;
	wire logic [flt_pkg::FLT_WORDS-1:0]   word_sel;
	wire logic [flt_pkg::FLT_WORDS-1:0]   wr_en;
	logic [7:0]                           wr_mask;
	logic [7:0]                           wval;
	// storage
	logic [7:0]                           mem_rdata;
	logic [31:0]                          mem_all;
	// read response
	logic [7:0]                           rd_mask;
	logic [7:0]                           rd_shaped;

	// ****************************************
	// resolution masks
	// ****************************************
	// bits that a low-resolution mode leaves unused store and read as zero
	function automatic logic [7:0] field_mask(input logic is_duty, input flt_pkg::flt_cfg_t cfg);
		logic [7:0] msk;
		msk = 8'hff;
		if (is_duty) begin
			if (!cfg.duty_high_res) begin
				msk = flt_pkg::FLT_LOW_RES_MASK_DUTY;
			end
		end else begin
			if (!cfg.temp_high_res) begin
				msk = flt_pkg::FLT_LOW_RES_MASK_LIMIT;
			end
		end
		return msk;
	endfunction

	// ****************************************
	// address decode
	// ****************************************
	assign in_range   = (bus_in.addr[7:2] == flt_pkg::FLT_ADDR_LIMIT_ELEVEN[7:2]);
	assign wr_req     = bus_in.wr && in_range;
	assign rd_req     = bus_in.rd && in_range;
	assign wr_allow   = wr_req && cfg_in.write_unlock;
	assign wr_is_duty = bus_in.addr[0];

	genvar w;
	generate
		for (w = 0; w < flt_pkg::FLT_WORDS; w++) begin : g_decode
			assign word_sel[w] = (bus_in.addr[1:0] == 2'(w));
			assign wr_en[w]    = wr_allow && word_sel[w];
		end
	endgenerate

	// ****************************************
	// write data
	// ****************************************
	assign wr_mask = field_mask(wr_is_duty, cfg_in);
	assign wval    = bus_in.wdata & wr_mask;

	flt_entry_store flt_entry_store_i (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.wr_en_in   (wr_en),
		.wdata_in   (wval),
		.rd_sel_in  (bus_in.addr[1:0]),
		.rdata_out  (mem_rdata),
		.all_out    (mem_all)
	);

	// ****************************************
	// comparison and duty selection
	// ****************************************
	function automatic logic [9:0] limit_of(input logic [7:0] raw, input logic hr, input logic [7:0] off);
		logic [9:0] lim;
		logic [9:0] off_hd;
		lim    = 10'h000;
		off_hd = {1'b0, off, 1'b0};
		// sign bit assumed zero; limit in half degrees, bit 7 is the half degree
		if (hr) begin
			lim = {2'b00, raw[6:0], raw[flt_pkg::FLT_HALF_DEGREE_BIT]};
		end else begin
			lim = {2'b00, raw[6:0], 1'b0};
		end
		return lim + off_hd;
	endfunction

	function automatic logic [7:0] duty_of(input logic [7:0] raw, input logic hr, input logic f22);
		logic [7:0] d;
		d = 8'h00;
		if (hr && f22) begin
			d = raw;
		end else begin
			d = {2'b00, raw[5:0]};
		end
		return d;
	endfunction

	// remote reading in half degrees
	logic [9:0]                                 temp_cmp;
	// per-entry results
	wire logic [flt_pkg::FLT_ENTRIES-1:0][9:0]  lim_hd;
	wire logic [flt_pkg::FLT_ENTRIES-1:0]       hit;
	wire logic [flt_pkg::FLT_ENTRIES-1:0][7:0]  duty_eff;
	logic                                       any_hit;
	logic [7:0]                                 duty_sel;

	// ****************************************
	// remote reading
	// ****************************************
	// high res keeps 9 bits (half degree), low res 8 bits (whole)
	always_comb begin
		if (cfg_in.temp_high_res) begin
			temp_cmp = {1'b0, remote_temp_in[10:2]};
		end else begin
			temp_cmp = {1'b0, remote_temp_in[10:3], 1'b0};
		end
	end

	// ****************************************
	// per-entry comparison
	// ****************************************
	// entry e keeps its limit in word 2e and its duty in word 2e+1
	genvar e;
	generate
		for (e = 0; e < flt_pkg::FLT_ENTRIES; e++) begin : g_entry
			wire logic       half_degree_bit;
			wire logic [6:0] whole_degrees;
			wire logic [1:0] duty_extended_bits;
			wire logic [5:0] duty_base_bits;
			assign half_degree_bit    = mem_all[16*e + flt_pkg::FLT_HALF_DEGREE_BIT];
			assign whole_degrees      = mem_all[16*e +: 7];
			assign duty_extended_bits = mem_all[16*e + 8 + flt_pkg::FLT_EXT_DUTY_LSB +: 2];
			assign duty_base_bits     = mem_all[16*e + 8 +: 6];
			assign lim_hd[e]          = limit_of({half_degree_bit, whole_degrees},
				cfg_in.temp_high_res, cfg_in.table_offset);
			assign hit[e]             = temp_cmp > lim_hd[e];
			assign duty_eff[e]        = duty_of({duty_extended_bits, duty_base_bits},
				cfg_in.duty_high_res, cfg_in.pwm_freq_22k5);
		end
	endgenerate

	// ****************************************
	// duty selection
	// ****************************************
	assign any_hit = |hit;

	// entry twelve is the higher step and takes precedence
	always_comb begin
		if (hit[1]) begin
			duty_sel = duty_eff[1];
		end else if (hit[0]) begin
			duty_sel = duty_eff[0];
		end else begin
			duty_sel = 8'h00;
		end
	end

	// ****************************************
	// read response
	// ****************************************
	// a word stored in high resolution still reads back masked once the mode drops
	assign rd_mask   = field_mask(st_reg.rd_duty, cfg_in);
	assign rd_shaped = mem_rdata & rd_mask;

	// ****************************************
	// state update
	// ****************************************
	always_comb begin
		st_next            = st_reg;
		st_next.hit_eleven = hit[0];
		st_next.hit_twelve = hit[1];
		st_next.duty_valid = any_hit;
		st_next.duty       = duty_sel;
		st_next.rd_pend    = rd_req;
		st_next.rd_duty    = bus_in.addr[0];
		st_next.rd_valid   = st_reg.rd_pend;
		st_next.rdata      = st_reg.rd_pend ? rd_shaped : 8'h00;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_valid_out   = st_reg.rd_valid;
	assign rdata_out      = st_reg.rdata;
	assign hit_eleven_out = st_reg.hit_eleven;
	assign hit_twelve_out = st_reg.hit_twelve;
	assign duty_valid_out = st_reg.duty_valid;
	assign duty_out       = st_reg.duty;
endmodule // flt_lut_top

// ===== dv/flt_lut_properties.sv
`timescale 1ns/1ns
module flt_lut_properties (
	// clock and reset
	input wire logic                  clk_in,
	input wire logic                  sys_rst_in,
	// register port
	input wire flt_pkg::flt_bus_req_t bus_in,
	input wire logic                  rd_valid_out,
	input wire logic [7:0]            rdata_out,
	// configuration and reading
	input wire flt_pkg::flt_cfg_t     cfg_in,
	input wire logic [10:0]           remote_temp_in,
	// table results
	input wire logic                  hit_eleven_out,
	input wire logic                  hit_twelve_out,
	input wire logic                  duty_valid_out,
	input wire logic [7:0]            duty_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	wire in_rng = bus_in.addr[7:2] == 6'h19;
	wire ext_ok = cfg_in.duty_high_res && cfg_in.pwm_freq_22k5;
	property p_rd_lat; bus_in.rd && in_rng |-> ##2 rd_valid_out; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
	property p_rd_oor; bus_in.rd && !in_rng |-> ##2 !rd_valid_out; endproperty
	a_rd_oor: assert property (p_rd_oor) else $error("unmapped read answered");
	property p_rd_src; rd_valid_out |-> $past(bus_in.rd, 2); endproperty
	a_rd_src: assert property (p_rd_src) else $error("spurious read answer");
	property p_rd_idle; !rd_valid_out |-> rdata_out == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
	property p_dv; duty_valid_out == (hit_eleven_out || hit_twelve_out); endproperty
	a_dv: assert property (p_dv) else $error("duty valid mismatch");
	property p_dz; !duty_valid_out |-> duty_out == 8'h00; endproperty
	a_dz: assert property (p_dz) else $error("duty without hit");
	property p_ext; duty_valid_out && !$past(ext_ok) |-> duty_out[7:6] == 2'b00; endproperty
	a_ext: assert property (p_ext) else $error("extended duty bits leaked");
	property p_zero; $past(remote_temp_in) == 11'h000 |-> !hit_eleven_out && !hit_twelve_out; endproperty
	a_zero: assert property (p_zero) else $error("hit at zero reading");
	property p_rd_lim;
		rd_valid_out && !$past(bus_in.addr[0], 2) && !$past(cfg_in.temp_high_res) |-> !rdata_out[7];
	endproperty
	a_rd_lim: assert property (p_rd_lim) else $error("low-res limit bit 7 read as one");
	property p_rd_duty;
		rd_valid_out && $past(bus_in.addr[0], 2) && !$past(cfg_in.duty_high_res) |-> rdata_out[7:6] == 2'b00;
	endproperty
	a_rd_duty: assert property (p_rd_duty) else $error("low-res duty bits 7:6 read as one");
	c_rd: cover property (rd_valid_out);
	c_both: cover property (hit_eleven_out && hit_twelve_out);
	c_ext: cover property (duty_out[7:6] != 2'b00);
endmodule // flt_lut_properties
bind flt_lut_top flt_lut_properties flt_lut_properties_i (.clk_in, .sys_rst_in, .bus_in, .rd_valid_out, .rdata_out,
	.cfg_in, .remote_temp_in, .hit_eleven_out, .hit_twelve_out, .duty_valid_out, .duty_out);

// ===== dv/flt_lut_top_tb.sv
`timescale 1ns/1ns
module flt_lut_top_tb;
	logic                  clk_in, sys_rst_in, rd_valid_out, hit_eleven_out, hit_twelve_out, duty_valid_out;
	flt_pkg::flt_bus_req_t bus_in;
	flt_pkg::flt_cfg_t     cfg_in;
	logic [10:0]           remote_temp_in;
	logic [7:0]            rdata_out, duty_out, m [4];
	int                    error_cnt = 0, tests_run = 0, cyc = 0;
	flt_lut_top flt_lut_top_i (.clk_in, .sys_rst_in, .bus_in, .rd_valid_out, .rdata_out, .cfg_in, .remote_temp_in,
		.hit_eleven_out, .hit_twelve_out, .duty_valid_out, .duty_out);
	initial begin
		clk_in = 0;
		forever #5 clk_in = ~clk_in;
	end
	task final_report;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			final_report();
		end
	end
	task chk(string n, logic [7:0] e, logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask
	// bits a low-resolution mode leaves unused read and store as zero
	function logic [7:0] maskf(logic duty, logic [7:0] d);
		return d & (duty ? (cfg_in.duty_high_res ? 8'hff : 8'h3f) : (cfg_in.temp_high_res ? 8'hff : 8'h7f));
	endfunction
	task wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_in) #1 bus_in = '{1'b1, 1'b0, a, d};
		@(posedge clk_in) #1 bus_in.wr = 1'b0;
		if (cfg_in.write_unlock && a[7:2] == 6'h19)
			m[a[1:0]] = maskf(a[0], d);
	endtask
	task rd(logic [7:0] a);
		@(posedge clk_in) #1 bus_in = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_in) #1 bus_in.rd = 1'b0;
		@(posedge clk_in);
		#1 chk("rd_valid", {7'h0, a[7:2] == 6'h19}, {7'h0, rd_valid_out});
		chk("rdata", a[7:2] == 6'h19 ? maskf(a[0], m[a[1:0]]) : 8'h00, rdata_out);
	endtask
	// limit and reading both in half degrees, offset in whole degrees
	function logic hitf(logic [7:0] l);
		logic [9:0] lh, rh;
		lh = {1'b0, l[6:0], cfg_in.temp_high_res & l[7]} + {1'b0, cfg_in.table_offset, 1'b0};
		rh = cfg_in.temp_high_res ? {1'b0, remote_temp_in[10:2]} : {1'b0, remote_temp_in[10:3], 1'b0};
		return rh > lh;
	endfunction
	function logic [7:0] dutyf(logic [7:0] d);
		return (cfg_in.duty_high_res && cfg_in.pwm_freq_22k5) ? d : {2'b00, d[5:0]};
	endfunction
	initial begin
		sys_rst_in = 1'b1;
		bus_in = '0;
		cfg_in = '0;
		remote_temp_in = '0;
		m = '{8'h7f, 8'h3f, 8'h7f, 8'h3f};
		void'($urandom(92808));
		repeat (16) @(posedge clk_in);
		#1 sys_rst_in = 1'b0;
		for (int a = 0; a < 4; a++)
			rd(8'h64 + a[7:0]);
		for (int i = 0; i < 60; i++) begin
			cfg_in = 12'($urandom);
			cfg_in.write_unlock = (i % 4 != 1);
			cfg_in.table_offset = (i % 8 == 7) ? 8'($urandom) : 8'($urandom_range(31, 0));
			for (int a = 0; a < 4; a++)
				wr(8'h64 + a[7:0], 8'($urandom));
			remote_temp_in = i == 0 ? 11'h000 : i == 1 ? 11'h7ff : 11'($urandom);
			repeat (2) @(posedge clk_in);
			#1 chk("hit_eleven", {7'h0, hitf(m[0])}, {7'h0, hit_eleven_out});
			chk("hit_twelve", {7'h0, hitf(m[2])}, {7'h0, hit_twelve_out});
			chk("duty", hitf(m[2]) ? dutyf(m[3]) : hitf(m[0]) ? dutyf(m[1]) : 8'h00, duty_out);
			rd(8'($urandom_range(8'h68, 8'h63)));
		end
		// reset again in mid-run: stored words return to their reset values
		@(posedge clk_in) #1 sys_rst_in = 1'b1;
		repeat (2) @(posedge clk_in);
		#1 sys_rst_in = 1'b0;
		m = '{8'h7f, 8'h3f, 8'h7f, 8'h3f};
		chk("duty_valid", 8'h00, {7'h0, duty_valid_out});
		for (int a = 0; a < 4; a++)
			rd(8'h64 + a[7:0]);
		final_report();
	end
endmodule // flt_lut_top_tb
